// ### dual_uart_front_map.svh
// Purpose: Offsets, bit positions, reset values and counts of the dual serial front end.
// Assumes: Included by bare name wherever a constant is needed.
// Notes:   Definitions only.
`ifndef DUAL_UART_FRONT_MAP_SVH
`define DUAL_UART_FRONT_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets on the host address lines
// ----------------------------------------------------------------------------
`define PRN_DATA_OFFSET    3'h0
`define STATUS_OFFSET      3'h6

// ----------------------------------------------------------------------------
// Modem status register and interrupt enable bit positions
// ----------------------------------------------------------------------------
`define STATUS_CTS_DELTA_BIT  0
`define STATUS_DSR_DELTA_BIT  1
`define STATUS_RING_FALL_BIT  2
`define STATUS_DCD_DELTA_BIT  3
`define STATUS_CTS_BIT        4
`define STATUS_DSR_BIT        5
`define STATUS_RING_BIT       6
`define STATUS_DCD_BIT        7
`define RING_INT_EN_BIT       3

// ----------------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------------
`define STATUS_RESET       8'h00
`define PRN_DATA_RESET     8'h00
`define READ_DATA_RESET    8'h00
`define BAUD_DIV_WIDTH     16
`define CHANNEL_COUNT      2

`endif

// ### dual_uart_front_pkg.sv
// Purpose: Types shared by the dual serial front end.
// Assumes: Constants live in dual_uart_front_map.svh.
// Notes:   Nothing is imported; users write the package name.
package dual_uart_front_pkg;

    typedef logic [7:0] byte_t;

    // One-hot owner of a host access.
    typedef enum logic [3:0] {
        TGT_NONE = 4'b0001,
        TGT_CH0  = 4'b0010,
        TGT_CH1  = 4'b0100,
        TGT_PRN  = 4'b1000
    } target_t;

endpackage

// ### modem_status_channel.sv
// Purpose: Modem status register and ring interrupt of one serial channel.
// Assumes: Modem pins are active low and synchronous to the clock.
// Notes:   A change arriving in the cycle of a clearing read is kept.
`timescale 1ns/1ps
`include "dual_uart_front_map.svh"
module modem_status_channel (
    input  wire logic        core_clk_in,     // System clock.
    input  wire logic        reset_n_in,      // Asynchronous reset, active low.
    input  wire logic        cts_n_in,        // Clear to send pin.
    input  wire logic        dsr_n_in,        // Data set ready pin.
    input  wire logic        ring_n_in,       // Ring indicator pin.
    input  wire logic        dcd_n_in,        // Carrier detect pin.
    input  wire logic        status_clear_in, // Host read of the status register.
    input  wire logic        ring_int_en_in,  // Ring interrupt enable bit.
    output logic [7:0]       status_out,      // Modem status register.
    output logic             irq_out          // Channel interrupt.
);
    logic [3:0] level_nxt;
    logic [3:0] delta_ev;
    logic [3:0] delta_nxt;
    logic       irq_nxt;

    // Levels are the asserted sense of the active-low pins.
    assign level_nxt = {~dcd_n_in, ~ring_n_in, ~dsr_n_in, ~cts_n_in};
    assign delta_ev[0] = level_nxt[0] != status_out[`STATUS_CTS_BIT];
    assign delta_ev[1] = level_nxt[1] != status_out[`STATUS_DSR_BIT];
    assign delta_ev[2] = level_nxt[2] & ~status_out[`STATUS_RING_BIT];
    assign delta_ev[3] = level_nxt[3] != status_out[`STATUS_DCD_BIT];
    // Set wins over the clearing read.
    assign delta_nxt = (status_out[3:0] & {4{~status_clear_in}}) | delta_ev;
    assign irq_nxt = ring_int_en_in & delta_nxt[`STATUS_RING_FALL_BIT];

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_out <= `STATUS_RESET;
            irq_out    <= 1'b0;
        end else begin
            status_out <= {level_nxt, delta_nxt};
            irq_out    <= irq_nxt;
        end
    end

endmodule // modem_status_channel

// ### dual_uart_front.sv
// Purpose: Chip select steering, printer data drive, baud clock feed and modem status of a dual serial device.
// Assumes: All inputs are synchronous to core_clk_in; the external clock is sampled as a level.
// Notes:   Receiver, transmitter, line status and printer handshake live elsewhere.
`timescale 1ns/1ps
`include "dual_uart_front_map.svh"
module dual_uart_front #(
    parameter int DIV_W = `BAUD_DIV_WIDTH
) (
    input  wire logic             core_clk_in,                // System clock, 125 MHz.
    input  wire logic             reset_n_in,                 // Asynchronous reset, active low.
    input  wire logic             read_n_in,                  // Host read strobe, active low.
    input  wire logic             write_n_in,                 // Host write strobe, active low.
    input  wire logic [2:0]       addr_in,                    // Host register address.
    input  wire logic [7:0]       data_in,                    // Host write data.
    input  wire logic             serial_ch0_select_n_in,     // Channel 0 select, active low.
    input  wire logic             serial_ch1_select_n_in,     // Channel 1 select, active low.
    input  wire logic             printer_port_select_n_in,   // Printer port select, active low.
    input  wire logic             parallel_output_enable_n_in,// Parallel drive enable, active low.
    input  wire logic [7:0]       parallel_data_lines_in,     // Parallel lines as read.
    input  wire logic             ext_clk_in,                 // External baud clock level.
    input  wire logic [DIV_W-1:0] baud_divisor_ch0_in,        // Channel 0 divisor.
    input  wire logic [DIV_W-1:0] baud_divisor_ch1_in,        // Channel 1 divisor.
    input  wire logic [1:0]       cts_n_in,                   // Clear to send per channel.
    input  wire logic [1:0]       dsr_n_in,                   // Data set ready per channel.
    input  wire logic [1:0]       ring_indicator_n_in,        // Ring indicator per channel.
    input  wire logic [1:0]       carrier_detect_n_in,        // Carrier detect per channel.
    input  wire logic [1:0]       ring_int_en_in,             // Interrupt enable bit 3 per channel.
    output logic [1:0]            serial_read_out,            // Gated read per channel.
    output logic [1:0]            serial_write_out,           // Gated write per channel.
    output logic                  printer_read_out,           // Gated printer read.
    output logic                  printer_write_out,          // Gated printer write.
    output logic [7:0]            read_data_out,              // Data captured at read start.
    output logic [7:0]            parallel_data_lines_out,    // Parallel drive value.
    output logic [7:0]            parallel_data_lines_oe_out, // Parallel drive enables.
    output logic [1:0]            baud_tick_out,              // Baud divisor tick per channel.
    output logic [7:0]            modem_status_reg_ch0_out,   // Channel 0 status register.
    output logic [7:0]            modem_status_reg_ch1_out,   // Channel 1 status register.
    output logic [1:0]            irq_out                     // Interrupt per channel.
);
    // ------------------------------------------------------------------------
    // Host decode
    // ------------------------------------------------------------------------
    dual_uart_front_pkg::target_t target;
    logic       read_n_prev_r;
    logic       write_n_prev_r;
    logic       read_start;
    logic       write_start;
    logic [1:0] ser_rd_nxt;
    logic [1:0] ser_wr_nxt;
    logic       prn_rd_nxt;
    logic       prn_wr_nxt;
    logic [1:0] status_clear;
    logic [7:0] status_w [2];
    logic [1:0] irq_w;
    logic [DIV_W-1:0] divisor_w [2];
    dual_uart_front_pkg::byte_t prn_data_r;
    dual_uart_front_pkg::byte_t prn_read_val;
    dual_uart_front_pkg::byte_t read_data_nxt;
    logic       ext_clk_prev_r;
    logic       ext_edge;

    // The first-listed select owns a clash in the decode; gated strobes follow every select; the host never asserts two.
    assign target = !serial_ch0_select_n_in   ? dual_uart_front_pkg::TGT_CH0 :
                    !serial_ch1_select_n_in   ? dual_uart_front_pkg::TGT_CH1 :
                    !printer_port_select_n_in ? dual_uart_front_pkg::TGT_PRN :
                                                dual_uart_front_pkg::TGT_NONE;
    assign ser_rd_nxt  = {~serial_ch1_select_n_in & ~read_n_in, ~serial_ch0_select_n_in & ~read_n_in};
    assign ser_wr_nxt  = {~serial_ch1_select_n_in & ~write_n_in, ~serial_ch0_select_n_in & ~write_n_in};
    assign prn_rd_nxt  = ~printer_port_select_n_in & ~read_n_in;
    assign prn_wr_nxt  = ~printer_port_select_n_in & ~write_n_in;
    assign read_start  = ~read_n_in & read_n_prev_r;
    assign write_start = ~write_n_in & write_n_prev_r;
    assign status_clear[0] = read_start & (target == dual_uart_front_pkg::TGT_CH0)
                             & (addr_in == `STATUS_OFFSET);
    assign status_clear[1] = read_start & (target == dual_uart_front_pkg::TGT_CH1)
                             & (addr_in == `STATUS_OFFSET);
    // With the drive off the port reads the external lines, else the latched byte.
    assign prn_read_val = parallel_output_enable_n_in ? parallel_data_lines_in : prn_data_r;

    always_comb begin
        read_data_nxt = read_data_out;
        if (read_start) begin
            case (target)
                dual_uart_front_pkg::TGT_CH0: read_data_nxt = (addr_in == `STATUS_OFFSET) ? status_w[0]
                                                                                          : `READ_DATA_RESET;
                dual_uart_front_pkg::TGT_CH1: read_data_nxt = (addr_in == `STATUS_OFFSET) ? status_w[1]
                                                                                          : `READ_DATA_RESET;
                dual_uart_front_pkg::TGT_PRN: read_data_nxt = (addr_in == `PRN_DATA_OFFSET) ? prn_read_val
                                                                                         : `READ_DATA_RESET;
                default: read_data_nxt = read_data_out;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            read_n_prev_r     <= 1'b1;
            write_n_prev_r    <= 1'b1;
            serial_read_out   <= 2'h0;
            serial_write_out  <= 2'h0;
            printer_read_out  <= 1'b0;
            printer_write_out <= 1'b0;
            read_data_out     <= `READ_DATA_RESET;
        end else begin
            read_n_prev_r     <= read_n_in;
            write_n_prev_r    <= write_n_in;
            serial_read_out   <= ser_rd_nxt;
            serial_write_out  <= ser_wr_nxt;
            printer_read_out  <= prn_rd_nxt;
            printer_write_out <= prn_wr_nxt;
            read_data_out     <= read_data_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Printer data drive
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prn_data_r                 <= `PRN_DATA_RESET;
            parallel_data_lines_out    <= `PRN_DATA_RESET;
            parallel_data_lines_oe_out <= 8'h00;
        end else begin
            if (write_start && target == dual_uart_front_pkg::TGT_PRN && addr_in == `PRN_DATA_OFFSET) begin
                prn_data_r <= data_in;
            end
            parallel_data_lines_out    <= prn_data_r;
            parallel_data_lines_oe_out <= {8{~parallel_output_enable_n_in}};
        end
    end

    // ------------------------------------------------------------------------
    // Baud divisors and modem status
    // ------------------------------------------------------------------------
    assign ext_edge     = ext_clk_in & ~ext_clk_prev_r;
    assign divisor_w[0] = baud_divisor_ch0_in;
    assign divisor_w[1] = baud_divisor_ch1_in;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ext_clk_prev_r <= 1'b0;
        end else begin
            ext_clk_prev_r <= ext_clk_in;
        end
    end

    for (genvar i = 0; i < `CHANNEL_COUNT; i++) begin : g_chan
        logic [DIV_W-1:0] cnt_r;
        logic             wrap;
        // A zero divisor stops the channel instead of ticking every edge.
        assign wrap = (divisor_w[i] != '0) && (cnt_r >= divisor_w[i] - DIV_W'(1));
        always_ff @(posedge core_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                cnt_r            <= '0;
                baud_tick_out[i] <= 1'b0;
            end else begin
                baud_tick_out[i] <= ext_edge & wrap;
                if (ext_edge) begin
                    cnt_r <= wrap ? '0 : cnt_r + DIV_W'(1);
                end
            end
        end

        modem_status_channel u_status (
            .core_clk_in     (core_clk_in),
            .reset_n_in      (reset_n_in),
            .cts_n_in        (cts_n_in[i]),
            .dsr_n_in        (dsr_n_in[i]),
            .ring_n_in       (ring_indicator_n_in[i]),
            .dcd_n_in        (carrier_detect_n_in[i]),
            .status_clear_in (status_clear[i]),
            .ring_int_en_in  (ring_int_en_in[i]),
            .status_out      (status_w[i]),
            .irq_out         (irq_w[i])
        );
    end

    assign modem_status_reg_ch0_out = status_w[0];
    assign modem_status_reg_ch1_out = status_w[1];
    assign irq_out                  = irq_w;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    drive_on_a: assert property (!parallel_output_enable_n_in |=>
        parallel_data_lines_oe_out == 8'hFF && parallel_data_lines_out == $past(prn_data_r))
        else $error("parallel lines not driven");
    float_off_a: assert property (parallel_output_enable_n_in |=>
        parallel_data_lines_oe_out == 8'h00)
        else $error("parallel lines not floated");
    ch_gate_a: assert property (((serial_read_out | serial_write_out) &
        ~$past({~serial_ch1_select_n_in, ~serial_ch0_select_n_in})) == 2'h0)
        else $error("serial strobe without select");
    ch0_pass_a: assert property (!serial_ch0_select_n_in && !write_n_in |=>
        serial_write_out[0])
        else $error("channel 0 write lost");
    prn_gate_a: assert property (printer_port_select_n_in |=>
        !printer_read_out && !printer_write_out)
        else $error("printer strobe without select");
    tick_src_a: assert property (baud_tick_out[0] || baud_tick_out[1] |->
        $past(ext_edge))
        else $error("baud tick without clock edge");
    dsr_level_a: assert property (##1
        modem_status_reg_ch0_out[`STATUS_DSR_BIT] == !$past(dsr_n_in[0]))
        else $error("dsr level wrong");
    dsr_delta_a: assert property ($changed(dsr_n_in[1]) |=>
        modem_status_reg_ch1_out[`STATUS_DSR_DELTA_BIT])
        else $error("dsr change lost");
    ring_level_a: assert property (##1
        modem_status_reg_ch1_out[`STATUS_RING_BIT] == !$past(ring_indicator_n_in[1]))
        else $error("ring level wrong");
    ring_fall_a: assert property ($fell(ring_indicator_n_in[0]) |=>
        modem_status_reg_ch0_out[`STATUS_RING_FALL_BIT])
        else $error("ring fall lost");
    ring_irq_a: assert property ($fell(ring_indicator_n_in[0]) && ring_int_en_in[0] |=>
        irq_out[0])
        else $error("ring interrupt missing");
    dcd_track_a: assert property ($changed(carrier_detect_n_in[0]) |=>
        modem_status_reg_ch0_out[`STATUS_DCD_DELTA_BIT]
        && modem_status_reg_ch0_out[`STATUS_DCD_BIT] == !$past(carrier_detect_n_in[0]))
        else $error("carrier detect status wrong");
    cts_track_a: assert property ($changed(cts_n_in[1]) |=>
        modem_status_reg_ch1_out[`STATUS_CTS_DELTA_BIT]
        && modem_status_reg_ch1_out[`STATUS_CTS_BIT] == !$past(cts_n_in[1]))
        else $error("clear to send status wrong");
    read_clear_a: assert property (status_clear[0] && !$changed(cts_n_in[0])
        && !$changed(dsr_n_in[0]) && !$fell(ring_indicator_n_in[0]) && !$changed(carrier_detect_n_in[0])
        |=> modem_status_reg_ch0_out[3:0] == 4'h0 && !irq_out[0])
        else $error("status flags not cleared");

    status_read_c: cover property (status_clear[1] ##1 read_data_out != 8'h00);
    ring_irq_c: cover property ($fell(ring_indicator_n_in[0]) && ring_int_en_in[0] ##1 irq_out[0]);
    prn_write_c: cover property (printer_write_out ##1 !parallel_output_enable_n_in ##1 parallel_data_lines_oe_out[0]);
    baud_both_c: cover property (baud_tick_out == 2'h3);

endmodule // dual_uart_front

// ### modem_model.sv
// Purpose: Modem pins that face both serial channels of the front end.
// Assumes: Pins are active low and rest high while the modem is idle.
// Notes:   Levels change only at the falling clock edge, clear of the sampling edge.
`timescale 1ns/1ps
module modem_model (
    input  wire logic       core_clk_in, // System clock.
    output logic      [1:0] cts_n_out,   // Clear to send per channel.
    output logic      [1:0] dsr_n_out,   // Data set ready per channel.
    output logic      [1:0] ring_n_out,  // Ring indicator per channel.
    output logic      [1:0] dcd_n_out    // Carrier detect per channel.
);
    initial begin
        cts_n_out  = 2'h3;
        dsr_n_out  = 2'h3;
        ring_n_out = 2'h3;
        dcd_n_out  = 2'h3;
    end

    // Pin k: 0 clear to send, 1 data set ready, 2 ring, 3 carrier detect.
    task automatic set_pin(input int ch, input int k, input logic v);
        @(negedge core_clk_in);
        case (k)
            0: cts_n_out[ch] = v;
            1: dsr_n_out[ch] = v;
            2: ring_n_out[ch] = v;
            default: dcd_n_out[ch] = v;
        endcase
    endtask
endmodule // modem_model

// ### tb_dual_uart_front.sv
// Purpose: Self-checking bench of the dual serial front end.
// Assumes: Inputs change at the falling clock edge; one select low at a time.
// Notes:   Every scenario is its own task and judges its own results.
`timescale 1ns/1ps
module tb_dual_uart_front;
    logic        clk = 1'b0, reset_n = 1'b0, rd_n = 1'b1, wr_n = 1'b1, ext = 1'b0;
    logic        s0_n = 1'b1, s1_n = 1'b1, sp_n = 1'b1, oe_n = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00, lines_in = 8'h3C, rdata, lines_out, lines_oe, stat0, stat1;
    logic [15:0] div0 = 16'h0002, div1 = 16'h0003;
    logic [1:0]  cts_n, dsr_n, ring_n, dcd_n, sr, sw, tick, irq, ring_en = 2'h1;
    logic        pr, pw;
    int          mismatches = 0, total_checks = 0;

    always #4 clk = ~clk;

    modem_model modem (.core_clk_in(clk), .cts_n_out(cts_n), .dsr_n_out(dsr_n), .ring_n_out(ring_n),
        .dcd_n_out(dcd_n));

    dual_uart_front #(.DIV_W(16)) uut (.core_clk_in(clk), .reset_n_in(reset_n), .read_n_in(rd_n),
        .write_n_in(wr_n), .addr_in(addr), .data_in(wdata), .serial_ch0_select_n_in(s0_n),
        .serial_ch1_select_n_in(s1_n), .printer_port_select_n_in(sp_n), .parallel_output_enable_n_in(oe_n),
        .parallel_data_lines_in(lines_in), .ext_clk_in(ext), .baud_divisor_ch0_in(div0),
        .baud_divisor_ch1_in(div1), .cts_n_in(cts_n), .dsr_n_in(dsr_n), .ring_indicator_n_in(ring_n),
        .carrier_detect_n_in(dcd_n), .ring_int_en_in(ring_en), .serial_read_out(sr), .serial_write_out(sw),
        .printer_read_out(pr), .printer_write_out(pw), .read_data_out(rdata),
        .parallel_data_lines_out(lines_out), .parallel_data_lines_oe_out(lines_oe), .baud_tick_out(tick),
        .modem_status_reg_ch0_out(stat0), .modem_status_reg_ch1_out(stat1), .irq_out(irq));

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] status_of(input int ch);
        return (ch == 1) ? stat1 : stat0;
    endfunction

    // Target s: 0 channel 0, 1 channel 1, 2 printer, 3 nothing selected.
    task automatic start(input int s, input bit r, input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        s0_n = (s != 0);
        s1_n = (s != 1);
        sp_n = (s != 2);
        addr = a;
        wdata = d;
        if (r) rd_n = 1'b0;
        else wr_n = 1'b0;
        @(negedge clk);
    endtask

    task automatic stop();
        {rd_n, wr_n, s0_n, s1_n, sp_n} = 5'h1F;
        @(negedge clk);
        @(negedge clk);
    endtask

    task automatic scen_select();
        logic [7:0] exp;
        for (int s = 0; s < 4; s++) begin
            for (int r = 0; r < 2; r++) begin
                exp = 8'h00;
                if (s < 2) exp[(r ? 4 : 2) + s] = 1'b1;
                if (s == 2) exp[r] = 1'b1;
                start(s, r, 3'h1, 8'h5A);
                check8("gated strobes", exp, {2'h0, sr, sw, pr, pw});
                stop();
                check8("strobes released", 8'h00, {2'h0, sr, sw, pr, pw});
            end
        end
    endtask

    task automatic scen_printer();
        start(2, 0, 3'h0, 8'hA5);
        stop();
        check8("parallel drive", 8'hA5, lines_out);
        check8("parallel enables", 8'hFF, lines_oe);
        start(0, 0, 3'h0, 8'h77);
        stop();
        check8("unselected printer write", 8'hA5, lines_out);
        oe_n = 1'b1;
        @(negedge clk);
        check8("parallel float", 8'h00, lines_oe);
        start(2, 1, 3'h0, 8'h00);
        check8("parallel lines read", 8'h3C, rdata);
        stop();
        oe_n = 1'b0;
        @(negedge clk);
        check8("parallel enables back", 8'hFF, lines_oe);
    endtask

    task automatic scen_modem();
        logic [7:0] lvl;
        for (int ch = 0; ch < 2; ch++) begin
            for (int k = 0; k < 4; k++) begin
                lvl = 8'h10 << k;
                modem.set_pin(ch, k, 1'b0);
                @(negedge clk);
                check8("status on assert", lvl | (8'h01 << k), status_of(ch));
                check8("ring interrupt", {7'h0, k == 2 && ring_en[ch]}, {7'h0, irq[ch]});
                start(ch, 1, 3'h6, 8'h00);
                check8("status read", lvl | (8'h01 << k), rdata);
                stop();
                check8("status cleared", lvl, status_of(ch));
                check8("interrupt cleared", 8'h00, {7'h0, irq[ch]});
                modem.set_pin(ch, k, 1'b1);
                @(negedge clk);
                check8("status on release", (k == 2) ? 8'h00 : (8'h01 << k), status_of(ch));
                start(ch, 1, 3'h6, 8'h00);
                stop();
            end
        end
    endtask

    task automatic scen_baud();
        int t0;
        int t1;
        t0 = 0;
        t1 = 0;
        for (int i = 0; i < 52; i++) begin
            @(negedge clk);
            if (i < 48) ext = (i % 4) < 2;
            t0 += (tick[0] === 1'b1);
            t1 += (tick[1] === 1'b1);
        end
        check8("channel 0 ticks", 8'd6, 8'(t0));
        check8("channel 1 ticks", 8'd4, 8'(t1));
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        check8("enables in reset", 8'h00, lines_oe);
        reset_n = 1'b1;
        @(negedge clk);
        check8("status after reset", 8'h00, stat0 | stat1);
        scen_select();
        scen_printer();
        scen_modem();
        scen_baud();
        report_and_stop();
    end
endmodule // tb_dual_uart_front
